// ### pkg/dd_link_if.sv
// Two-wire link between the bus master and the display driver port
`timescale 1ns/100ps
interface dd_link_if;
  logic host_scl_o;     // Master clock drive value
  logic host_scl_oe_n;  // Master clock enable, low drives
  logic host_sda_o;     // Master data drive value
  logic host_sda_oe_n;  // Master data enable, low drives
  logic dev_sda_o;      // Device data drive value
  logic dev_sda_oe_n;   // Device data enable, low drives
  logic scl;            // Resolved clock line with pull-up
  logic sda;            // Resolved data line with pull-up

  // Open-drain resolution, released lines float high
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host (input sda, output host_scl_o, output host_scl_oe_n, output host_sda_o, output host_sda_oe_n);
endinterface

// ### pkg/dd_pkg.sv
// Shared constants for both ends of the two-wire display driver link
package dd_pkg;
  // Clock and link timing
  localparam int        CLK_PERIOD_NS = 4;                        // Core clock period
  localparam int        SCL_PERIOD_NS = 80;                       // Serial clock period made by the master
  localparam int        QTR_CYC_INT   = (SCL_PERIOD_NS / 4) / CLK_PERIOD_NS; // Quarter bit in cycles
  localparam logic [3:0] QTR_CYC      = 4'(QTR_CYC_INT < 1 ? 1 : QTR_CYC_INT); // At least one cycle
  // Framing
  localparam logic [3:0] BYTE_BITS    = 4'h8;                     // Data bits before the ninth clock
  localparam logic [2:0] ADDR_FIXED   = 3'h6;                     // Fixed upper slave address bits
  // Address select pin sensing codes
  localparam logic [1:0] PIN_GND      = 2'h0;                     // Pin tied to ground
  localparam logic [1:0] PIN_SUPPLY   = 2'h1;                     // Pin tied to supply
  localparam logic [1:0] PIN_SDA      = 2'h2;                     // Pin tied to data line
  localparam logic [1:0] PIN_SCL      = 2'h3;                     // Pin tied to clock line
  // Register pointer
  localparam int         REG_COUNT    = 128;                      // Internal byte registers
  localparam logic [7:0] PTR_RESET    = 8'h00;                    // Pointer after reset
  localparam logic [6:0] PTR_HOLD     = 7'h7F;                    // Pointer stops here
  localparam logic [6:0] PTR_RESERVED = 7'h0D;                    // Location never written
  // Write stream buffer
  localparam int         FIFO_WIDTH   = 15;                       // Register index plus data byte
  localparam int         FIFO_DEPTH   = 4;                        // Words buffered
endpackage

// ### rtl/dd_master.sv
// Two-wire bus master end that drives the display driver port
`timescale 1ns/100ps
module dd_master
  import dd_pkg::*;
(
  input  wire logic       i_clk,           // Core clock
  input  wire logic       i_reset,         // Synchronous reset
  dd_link_if.host         link,            // Two-wire bus pins
  input  wire logic       i_cmd_valid,     // Transaction request
  output logic            o_cmd_ready,     // Master idle, request taken
  input  wire logic       i_cmd_read,      // One-byte read from pointer
  input  wire logic [6:0] i_cmd_dev_addr,  // Slave address
  input  wire logic [7:0] i_cmd_reg,       // Command byte for writes
  input  wire logic       i_cmd_has_data,  // Write carries a data byte
  input  wire logic [7:0] i_cmd_data,      // Data byte for writes
  output logic            o_done,          // Transaction finished pulse
  output logic            o_nack,          // Last transaction saw a nack
  output logic      [7:0] o_rd_data        // Byte from last read
);
  typedef enum logic [3:0] {
    M_IDLE  = 4'h1,
    M_START = 4'h2,
    M_BIT   = 4'h4,
    M_STOP  = 4'h8
  } dd_mst_state_t;

  dd_mst_state_t state_reg;                // Master state
  logic [3:0]    qtr_reg;                  // Quarter-bit timer
  logic [1:0]    phase_reg;                // Quarter within bit
  logic [3:0]    bit_reg;                  // Bit in byte, 8 is ack
  logic [1:0]    byte_reg;                 // Byte in transaction
  logic [7:0]    shift_reg;                // Byte shifter
  logic          rw_reg;                   // Read transaction
  logic          has_data_reg;             // Data byte follows command
  logic [7:0]    cmd_reg;                  // Command byte kept
  logic [7:0]    data_reg;                 // Data byte kept
  logic          scl_low_reg;              // Pull clock low
  logic          sda_low_reg;              // Pull data low
  logic          sda_m, sda_s;             // Data line synchroniser
  logic          done_reg;                 // Done pulse
  logic          nack_reg;                 // Nack seen
  logic [7:0]    rd_reg;                   // Read result

  // Decode
  wire tick      = (qtr_reg == QTR_CYC - 4'h1);
  wire receiving = rw_reg & (byte_reg == 2'h1);
  wire [1:0] last_byte = (rw_reg | ~has_data_reg) ? 2'h1 : 2'h2;
  wire [7:0] next_byte = (byte_reg == 2'h0) ? cmd_reg : data_reg;
  wire accept    = i_cmd_valid & (state_reg == M_IDLE);

  assign o_cmd_ready        = (state_reg == M_IDLE);
  assign o_done             = done_reg;
  assign o_nack             = nack_reg;
  assign o_rd_data          = rd_reg;
  assign link.host_scl_o    = 1'b0;
  assign link.host_scl_oe_n = ~scl_low_reg;
  assign link.host_sda_o    = 1'b0;
  assign link.host_sda_oe_n = ~sda_low_reg;

  // Data line synchroniser
  always_ff @(posedge i_clk)
    {sda_m, sda_s} <= {link.sda, sda_m};

  // Quarter timer, free while busy
  always_ff @(posedge i_clk)
    if (i_reset | accept | tick)
      qtr_reg <= 4'h0;
    else
      qtr_reg <= qtr_reg + 4'h1;

  // Sequencer
  always_ff @(posedge i_clk)
    if (i_reset)
    begin
      state_reg    <= M_IDLE;
      phase_reg    <= 2'h0;
      bit_reg      <= 4'h0;
      byte_reg     <= 2'h0;
      shift_reg    <= 8'h00;
      rw_reg       <= 1'b0;
      has_data_reg <= 1'b0;
      cmd_reg      <= 8'h00;
      data_reg     <= 8'h00;
      scl_low_reg  <= 1'b0;
      sda_low_reg  <= 1'b0;
      done_reg     <= 1'b0;
      nack_reg     <= 1'b0;
      rd_reg       <= 8'h00;
    end
    else
    begin
      done_reg <= 1'b0;
      unique case (state_reg)
        M_IDLE:
          if (accept)
          begin
            state_reg    <= M_START;
            phase_reg    <= 2'h0;
            rw_reg       <= i_cmd_read;
            has_data_reg <= i_cmd_has_data;
            cmd_reg      <= i_cmd_reg;
            data_reg     <= i_cmd_data;
            shift_reg    <= {i_cmd_dev_addr, i_cmd_read};
            nack_reg     <= 1'b0;
          end
        M_START:
          if (tick & (phase_reg == 2'h0))
          begin
            sda_low_reg <= 1'b1;           // Data falls while clock high
            phase_reg   <= 2'h1;
          end
          else if (tick)
          begin
            scl_low_reg <= 1'b1;
            sda_low_reg <= ~shift_reg[7];
            bit_reg     <= 4'h0;
            byte_reg    <= 2'h0;
            phase_reg   <= 2'h0;
            state_reg   <= M_BIT;
          end
        M_BIT:
          if (tick)
          begin
            phase_reg <= phase_reg + 2'h1;
            unique case (phase_reg)
              2'h0: scl_low_reg <= 1'b0;   // Clock high, data held
              2'h1:
                if (bit_reg == BYTE_BITS)
                  nack_reg <= nack_reg | (~receiving & sda_s);
                else if (receiving)
                  shift_reg <= {shift_reg[6:0], sda_s};
              2'h2: scl_low_reg <= 1'b1;
              2'h3:
                if (bit_reg == BYTE_BITS & (nack_reg | byte_reg == last_byte))
                begin
                  sda_low_reg <= 1'b1;     // Prepare stop
                  if (rw_reg)
                    rd_reg <= shift_reg;
                  phase_reg <= 2'h0;
                  state_reg <= M_STOP;
                end
                else if (bit_reg == BYTE_BITS)
                begin
                  byte_reg    <= byte_reg + 2'h1;
                  bit_reg     <= 4'h0;
                  shift_reg   <= next_byte;
                  sda_low_reg <= ~(rw_reg | next_byte[7]);
                end
                else
                begin
                  bit_reg     <= bit_reg + 4'h1;
                  sda_low_reg <= ~receiving & (bit_reg != BYTE_BITS - 4'h1) & ~shift_reg[6];
                  if (~receiving)
                    shift_reg <= {shift_reg[6:0], 1'b0};
                end
            endcase
          end
        M_STOP:
          if (tick & (phase_reg == 2'h0))
          begin
            scl_low_reg <= 1'b0;
            phase_reg   <= 2'h1;
          end
          else if (tick & (phase_reg == 2'h1))
          begin
            sda_low_reg <= 1'b0;           // Data rises while clock high
            phase_reg   <= 2'h2;
          end
          else if (tick)
          begin
            done_reg  <= 1'b1;
            state_reg <= M_IDLE;
          end
      endcase
    end
endmodule

// ### rtl/dd_slave.sv
// Display driver two-wire slave port with its write stream buffer
`timescale 1ns/100ps

// Small synchronous FIFO with valid/ready on both sides
module dd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk,     // Core clock
  input  wire logic             i_reset,   // Synchronous reset
  input  wire logic             i_valid,   // Write side word offered
  output logic                  o_ready,   // Write side room left
  input  wire logic [WIDTH-1:0] i_data,    // Write side word
  output logic                  o_valid,   // Read side word present
  input  wire logic             i_ready,   // Read side takes word
  output logic      [WIDTH-1:0] o_data     // Read side word
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];       // Storage
  logic [PW-1:0]    wr_reg;                // Write index
  logic [PW-1:0]    rd_reg;                // Read index
  logic [PW:0]      cnt_reg;               // Fill level

  wire push = i_valid & o_ready;           // Word enters
  wire pop  = o_valid & i_ready;           // Word leaves

  assign o_ready = (cnt_reg != (PW+1)'(DEPTH));
  assign o_valid = (cnt_reg != '0);
  assign o_data  = mem_reg[rd_reg];

  // Storage write, no reset needed
  always_ff @(posedge i_clk)
    if (push)
      mem_reg[wr_reg] <= i_data;

  // Index and level update
  always_ff @(posedge i_clk)
    if (i_reset)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= (wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + PW'(1);
      if (pop)
        rd_reg <= (rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + PW'(1);
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
endmodule

// Notes on behaviour
// - One data bit per clock, stable high
// - Ninth clock carries acknowledge each byte
// - Receiver holds data low on ninth clock
// - Device acknowledges bytes it receives, nacks data when buffer full
// - Master acknowledges bytes device sends; dd_master reads one byte and nacks it
// - Seven address bits then direction bit
// - Upper three address bits are 110
// - Two four-state pins set low bits
// - Upper pin bits 3:2, lower 1:0
// - Write starts with command byte
// - Stop after command only stores pointer
// - First data byte to selected register
// - Later bytes go to following registers
// - Pointer holds at 7F; 0D unwritten
// - Reads continue until nack or stop
module dd_slave
  import dd_pkg::*;
(
  input  wire logic       i_clk,                    // Core clock
  input  wire logic       i_reset,                  // Synchronous reset
  dd_link_if.device       link,                     // Two-wire bus pins
  input  wire logic [1:0] i_addr_select_pin_upper,  // Sensed state of upper select pin
  input  wire logic [1:0] i_addr_select_pin_lower,  // Sensed state of lower select pin
  output logic            o_wr_valid,               // Written register word present
  input  wire logic       i_wr_ready,               // User takes written word
  output logic      [6:0] o_wr_index,               // Register index written
  output logic      [7:0] o_wr_data,                // Byte written
  output logic      [7:0] o_ptr,                    // Current register pointer
  output logic            o_busy                    // Transfer under way since start, any address until address byte checked
);
  typedef enum logic [6:0] {
    S_IDLE     = 7'h01,
    S_ADDR     = 7'h02,
    S_ACK_ADDR = 7'h04,
    S_RX       = 7'h08,
    S_ACK_RX   = 7'h10,
    S_TX       = 7'h20,
    S_ACK_TX   = 7'h40
  } dd_slv_state_t;

  // Synchronisers and edge history
  logic scl_m, scl_s, scl_d;                        // Clock line stages
  logic sda_m, sda_s, sda_d;                        // Data line stages
  logic [1:0] up_m, up_s, lo_m, lo_s;               // Select pin stages
  logic [3:0] addr_low_reg;                         // Captured low address bits

  // Protocol state
  dd_slv_state_t state_reg, state_next;             // Slave state
  logic [3:0]    cnt_reg, cnt_next;                 // Bit counter
  logic [7:0]    shift_reg, shift_next;             // Shift register
  logic [7:0]    ptr_reg, ptr_next;                 // Register pointer
  logic          first_reg, first_next;             // Next byte is command byte
  logic          low_reg, low_next;                 // Pull data line low
  logic [7:0]    regs_mem [REG_COUNT];              // Internal registers
  logic          fifo_ready;                        // Room in write stream

  // Line event decode
  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;
  wire byte_done = scl_fall & (cnt_reg == BYTE_BITS);
  wire addr_hit  = (shift_reg[7:5] == ADDR_FIXED) & (shift_reg[4:1] == addr_low_reg);
  wire [7:0] rd_byte = regs_mem[ptr_reg[6:0]];
  wire [7:0] ptr_adv = (ptr_reg[6:0] == PTR_HOLD) ? ptr_reg : {ptr_reg[7], ptr_reg[6:0] + 7'h01};
  wire data_rx   = (state_reg == S_RX) & byte_done & ~first_reg;
  wire push      = data_rx & fifo_ready;
  wire store     = push & (ptr_reg[6:0] != PTR_RESERVED);

  assign link.dev_sda_o    = 1'b0;
  assign link.dev_sda_oe_n = ~low_reg;
  assign o_ptr             = ptr_reg;
  assign o_busy            = (state_reg != S_IDLE);

  // Two-stage capture of the lines, third stage for edge history
  always_ff @(posedge i_clk)
    if (i_reset)
    begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end
    else
    begin
      {scl_m, scl_s, scl_d} <= {link.scl, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {link.sda, sda_m, sda_s};
    end

  // Strap pins sampled while reset is held
  always_ff @(posedge i_clk)
  begin
    {up_m, up_s} <= {i_addr_select_pin_upper, up_m};
    {lo_m, lo_s} <= {i_addr_select_pin_lower, lo_m};
    if (i_reset)
      addr_low_reg <= {up_s, lo_s};
  end

  // Register array write
  always_ff @(posedge i_clk)
    if (store)
      regs_mem[ptr_reg[6:0]] <= shift_reg;

  // Next-state decode
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    ptr_next   = ptr_reg;
    first_next = first_reg;
    low_next   = low_reg;
    if (start_det)
    begin
      // Start or repeated start restarts addressing
      state_next = S_ADDR;
      cnt_next   = 4'h0;
      low_next   = 1'b0;
    end
    else if (stop_det)
    begin
      // Stop ends everything, pointer kept
      state_next = S_IDLE;
      low_next   = 1'b0;
    end
    else
    begin
      if (scl_rise & (state_reg == S_ADDR || state_reg == S_RX))
      begin
        shift_next = {shift_reg[6:0], sda_s};
        cnt_next   = cnt_reg + 4'h1;
      end
      else if (scl_rise & (state_reg == S_TX))
        cnt_next = cnt_reg + 4'h1;
      unique case (state_reg)
        S_IDLE: ;
        S_ADDR:
          if (byte_done)
          begin
            state_next = addr_hit ? S_ACK_ADDR : S_IDLE;
            low_next   = addr_hit;
            first_next = 1'b1;
          end
        S_ACK_ADDR:
          if (scl_fall & shift_reg[0])
          begin
            // Read: put first bit out at once
            shift_next = rd_byte;
            low_next   = ~rd_byte[7];
            cnt_next   = 4'h0;
            state_next = S_TX;
          end
          else if (scl_fall)
          begin
            low_next   = 1'b0;
            cnt_next   = 4'h0;
            state_next = S_RX;
          end
        S_RX:
          if (byte_done & first_reg)
          begin
            ptr_next   = shift_reg;
            first_next = 1'b0;
            low_next   = 1'b1;
            state_next = S_ACK_RX;
          end
          else if (push)
          begin
            ptr_next   = ptr_adv;
            low_next   = 1'b1;
            state_next = S_ACK_RX;
          end
          else if (data_rx)
            state_next = S_IDLE;                    // Buffer full: byte refused by nack
        S_ACK_RX:
          if (scl_fall)
          begin
            low_next   = 1'b0;
            cnt_next   = 4'h0;
            state_next = S_RX;
          end
        S_TX:
          if (scl_fall & (cnt_reg == BYTE_BITS))
          begin
            low_next   = 1'b0;                      // Release for master acknowledge
            ptr_next   = ptr_adv;
            cnt_next   = 4'h0;
            state_next = S_ACK_TX;
          end
          else if (scl_fall)
          begin
            low_next   = ~shift_reg[6];
            shift_next = {shift_reg[6:0], 1'b0};
          end
        S_ACK_TX:
          if (scl_rise)
          begin
            state_next = sda_s ? S_IDLE : S_ACK_TX;
            cnt_next   = 4'h1;
          end
          else if (scl_fall & (cnt_reg == 4'h1))
          begin
            shift_next = rd_byte;
            low_next   = ~rd_byte[7];
            cnt_next   = 4'h0;
            state_next = S_TX;
          end
      endcase
    end
  end

  // State registers
  always_ff @(posedge i_clk)
    if (i_reset)
    begin
      state_reg <= S_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg   <= PTR_RESET;
      first_reg <= 1'b0;
      low_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg   <= ptr_next;
      first_reg <= first_next;
      low_reg   <= low_next;
    end

  // Written words to the user side
  dd_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_valid (data_rx),
    .o_ready (fifo_ready),
    .i_data  ({ptr_reg[6:0], shift_reg}),
    .o_valid (o_wr_valid),
    .i_ready (i_wr_ready),
    .o_data  ({o_wr_index, o_wr_data})
  );
endmodule

// ### testbench/dd_link_assertions.sv
// Protocol checker for the two-wire link between master and display port
`timescale 1ns/100ps
module dd_link_checker (
  input  wire logic       i_clk,                   // Core clock
  input  wire logic       i_reset,                 // Synchronous reset
  input  wire logic       scl,                     // Resolved clock line
  input  wire logic       sda,                     // Resolved data line
  input  wire logic       dev_sda_oe_n,            // Device data enable, low drives
  input  wire logic [1:0] i_addr_select_pin_upper, // Upper strap code
  input  wire logic [1:0] i_addr_select_pin_lower  // Lower strap code
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic       scl_q, sda_q, first, rd_mode, active; // Line history and frame state
  logic [3:0] bit_cnt;                               // Clock rises within a byte
  logic [7:0] shift;                                 // Bits of the current byte
  wire        scl_rise = scl & ~scl_q;               // Clock rising edge
  wire        start_c  = scl & scl_q & sda_q & ~sda; // Data falls, clock high
  wire        stop_c   = scl & scl_q & ~sda_q & sda; // Data rises, clock high
  wire        ninth    = scl_rise & (bit_cnt == 4'h8); // Acknowledge clock
  wire        addr_hit = shift[7:1] == {3'h6, i_addr_select_pin_upper, i_addr_select_pin_lower};
  // Follow framing on the resolved lines
  always_ff @(posedge i_clk)
  begin
    scl_q <= i_reset | scl;
    sda_q <= i_reset | sda;
    if (i_reset | start_c | stop_c)
    begin
      bit_cnt <= 4'h0;
      first   <= start_c;
      rd_mode <= 1'b0;
      active  <= start_c;
    end
    else if (scl_rise)
    begin
      bit_cnt <= ninth ? 4'h0 : bit_cnt + 4'h1;
      shift   <= ninth ? shift : {shift[6:0], sda};
      first   <= first & ~ninth;
      rd_mode <= rd_mode | (ninth & first & shift[0]);
    end
  end
  dev_stable_a: assert property (scl && scl_q |-> $stable(dev_sda_oe_n))
    else $error("device data drive moved while clock high");
  clk_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  addr_ack_a: assert property (ninth && first |-> !dev_sda_oe_n == addr_hit)
    else $error("address acknowledge wrong");
  ack_low_a: assert property (ninth && !dev_sda_oe_n |-> (!sda && !dev_sda_oe_n) [*8])
    else $error("acknowledge not held low");
  wr_ack_only_a: assert property (scl_rise && !rd_mode && !ninth |-> dev_sda_oe_n)
    else $error("device drove data outside acknowledge");
  rd_release_a: assert property (ninth && rd_mode |-> dev_sda_oe_n)
    else $error("device held line on master acknowledge");
  idle_release_a: assert property (!active |-> dev_sda_oe_n)
    else $error("device drove idle bus");
  byte_frame_a: assert property (stop_c |-> bit_cnt == 4'h1)
    else $error("stop not after whole bytes");
endmodule

// ### testbench/display_driver_i2c_slave_port_bench.sv
// Self-checking bench joining the display port to its bus master
`timescale 1ns/100ps
module display_driver_i2c_slave_port_bench;
  import dd_pkg::*;
  localparam logic [6:0] DEV = 7'h6C; // Address with straps scl and gnd
  logic       i_clk, i_reset, cmd_valid, cmd_read, has_data, wr_ready; // Driven inputs
  logic [1:0] pin_up, pin_lo;       // Strap codes
  logic [6:0] dev_addr;             // Target address
  logic [7:0] cmd_reg, cmd_data;    // Command and data bytes
  logic       cmd_ready, done, nack, wr_valid, busy; // Observed flags
  logic [6:0] wr_index;             // Streamed register index
  logic [7:0] wr_data, ptr, rd_data; // Streamed byte, pointer, read byte
  int         err_count, n_tests, cycles; // Bookkeeping
  dd_link_if link ();
  dd_slave i_dd_slave (.i_clk(i_clk), .i_reset(i_reset), .link(link), .i_addr_select_pin_upper(pin_up),
    .i_addr_select_pin_lower(pin_lo), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr_index(wr_index),
    .o_wr_data(wr_data), .o_ptr(ptr), .o_busy(busy));
  dd_master i_dd_master (.i_clk(i_clk), .i_reset(i_reset), .link(link), .i_cmd_valid(cmd_valid),
    .o_cmd_ready(cmd_ready), .i_cmd_read(cmd_read), .i_cmd_dev_addr(dev_addr), .i_cmd_reg(cmd_reg),
    .i_cmd_has_data(has_data), .i_cmd_data(cmd_data), .o_done(done), .o_nack(nack), .o_rd_data(rd_data));
  dd_link_checker i_dd_link_checker (.i_clk(i_clk), .i_reset(i_reset), .scl(link.scl), .sda(link.sda),
    .dev_sda_oe_n(link.dev_sda_oe_n), .i_addr_select_pin_upper(pin_up), .i_addr_select_pin_lower(pin_lo));
  // Core clock
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // Hang guard
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      err_count++;
      complete_run();
    end
  end
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Reset with given straps held
  task automatic reset_dut(input logic [1:0] up, input logic [1:0] lo);
    @(posedge i_clk);
    #1 i_reset = 1'b1;
    pin_up = up;
    pin_lo = lo;
    repeat (20) @(posedge i_clk);
    #1 i_reset = 1'b0;
    check({busy, ptr}, 9'h000);
  endtask
  // One master transaction, then its nack flag
  task automatic xact(input logic rd, input logic [6:0] a, input logic [7:0] r, input logic hd,
                      input logic [7:0] d, input logic exp_nack);
    int n;
    @(posedge i_clk);
    #1 cmd_valid = 1'b1;
    cmd_read = rd;
    dev_addr = a;
    cmd_reg = r;
    has_data = hd;
    cmd_data = d;
    @(posedge i_clk);
    #1 cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(posedge i_clk);
      #1 n++;
    end
    check({done, nack, cmd_ready, busy}, {1'b1, exp_nack, 2'b10});
  endtask
  // Take one streamed word
  task automatic pop(input logic [6:0] idx, input logic [7:0] d);
    @(posedge i_clk);
    #1 check({wr_valid, wr_index, wr_data}, {1'b1, idx, d});
    wr_ready = 1'b1;
    @(posedge i_clk);
    #1 wr_ready = 1'b0;
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Test sequence
  initial
  begin
    {i_reset, cmd_valid, cmd_read, has_data, wr_ready} = 5'h10;
    {pin_up, pin_lo, dev_addr, cmd_reg, cmd_data} = 27'h0;
    {err_count, n_tests, cycles} = 0;
    // Each strap code on both pins, own and neighbouring address
    for (int k = 0; k < 4; k++)
    begin
      reset_dut(2'(k), 2'(3 - k));
      xact(0, {3'h6, 2'(k), 2'(3 - k)}, 8'h10 + 8'(k), 0, 8'h00, 0);
      check({wr_valid, ptr}, {1'b0, 8'h10 + 8'(k)});
      xact(0, {3'h6, 2'(k), 2'(3 - k) ^ 2'h1}, 8'h20, 0, 8'h00, 1);
      check(ptr, 8'h10 + 8'(k));
    end
    xact(0, 7'h2C, 8'h20, 0, 8'h00, 1);
    xact(0, 7'h7C, 8'h20, 0, 8'h00, 1);
    // Data writes, hold at top, reserved place
    xact(0, DEV, 8'h05, 1, 8'hA5, 0);
    pop(7'h05, 8'hA5);
    check(ptr, 8'h06);
    xact(0, DEV, 8'h7F, 1, 8'h3C, 0);
    pop(7'h7F, 8'h3C);
    check(ptr, 8'h7F);
    xact(0, DEV, 8'h0D, 1, 8'h99, 0);
    pop(7'h0D, 8'h99);
    check(ptr, 8'h0E);
    // Read back through the pointer
    xact(0, DEV, 8'h05, 0, 8'h00, 0);
    xact(1, DEV, 8'h00, 0, 8'h00, 0);
    check({rd_data, ptr}, 16'hA506);
    // Fill the buffer until it refuses, then drain
    for (int i = 0; i < 5; i++)
      xact(0, DEV, 8'h20 + 8'(i), 1, 8'h50 + 8'(i), i == 4);
    for (int i = 0; i < 4; i++)
      pop(7'h20 + 7'(i), 8'h50 + 8'(i));
    check(wr_valid, 1'b0);
    // Fifth reset mid-run
    reset_dut(2'h3, 2'h0);
    xact(0, DEV, 8'h41, 1, 8'h77, 0);
    pop(7'h41, 8'h77);
    complete_run();
  end
endmodule
